// >>> design/acps_cfg.svh
// register offsets, field positions, reset values and divider counts
//
// Operation
// - select bits 6-4 choose clock; 000 gives /2, 010 /32, 110 /64
// - low two select bits both one selects the internal rc clock
// - bits 3-0 hold four per-pin analog or digital select bits
// - a select bit of one routes its pin to the analog input path
// - a select bit of zero leaves its pin to digital port functions
// - analog pins lose digital input buffer, weak pull-up and change interrupt
`ifndef ACPS_CFG_SVH
`define ACPS_CFG_SVH

// register map
`define ACPS_ADDR_SELECT 8'h9F
`define ACPS_SELECT_RESET 7'h0F
`define ACPS_READ_IDLE 8'h00

// field positions inside the select register
`define ACPS_CLK_HI 6
`define ACPS_CLK_LO 4
`define ACPS_PIN_HI 3
`define ACPS_PIN_LO 0

// clock select codes
`define ACPS_CODE_DIV2 3'h0
`define ACPS_CODE_DIV8 3'h1
`define ACPS_CODE_DIV32 3'h2
`define ACPS_CODE_DIV4 3'h4
`define ACPS_CODE_DIV16 3'h5
`define ACPS_CODE_DIV64 3'h6
`define ACPS_RC_MASK 2'h3

// half periods minus one, in system clocks
`define ACPS_HALF_DIV2 5'h00
`define ACPS_HALF_DIV4 5'h01
`define ACPS_HALF_DIV8 5'h03
`define ACPS_HALF_DIV16 5'h07
`define ACPS_HALF_DIV32 5'h0F
`define ACPS_HALF_DIV64 5'h1F
`define ACPS_HALF_ZERO 5'h00
`define ACPS_HALF_STEP 5'h01

`endif

// >>> design/acps_pkg.sv
// types shared by the conversion clock and analog pin select block
package acps_pkg;

    // register port request from software
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } acps_bus_req_type;

    // per-pin controls handed to the port logic
    typedef struct packed {
        logic [3:0] analog_path_enable;
        logic [3:0] digital_input;
        logic [3:0] pullup_enable;
        logic [3:0] change_flag;
        logic [3:0] direction_conflict;
    } acps_pin_out_type;

    // all state of the block
    typedef struct packed {
        logic [6:0] select;
        logic [3:0] pin_sync1;
        logic [3:0] pin_sync2;
        logic [3:0] pin_prev;
        logic rc_sync1;
        logic rc_sync2;
        logic [4:0] div_count;
        logic conv_clock;
        logic conv_clock_is_rc;
        logic [7:0] read_data;
        acps_pin_out_type pins;
    } acps_state_type;

endpackage

// >>> design/acps_top.sv
// conversion clock select and analog pin select register with pin gating
`timescale 1ns/10ps
`include "acps_cfg.svh"

module acps_top (
    input wire logic clock,
    input wire logic reset_n,
    input wire acps_pkg::acps_bus_req_type bus_req,
    output logic [7:0] read_data,
    input wire logic rc_osc_in,
    input wire logic [3:0] converter_input_pins,
    input wire logic [3:0] pin_direction_bits,
    input wire logic [3:0] pullup_request,
    input wire logic [3:0] change_int_enable,
    output logic conv_clock,
    output logic conv_clock_is_rc,
    output acps_pkg::acps_pin_out_type pin_out
);

    // =========================================================
    // decode helpers

    // half period minus one of the divided conversion clock
    function automatic logic [4:0] half_period(input logic [2:0] code);
        logic [4:0] half;
        half = `ACPS_HALF_DIV2;
        if (code == `ACPS_CODE_DIV2) begin
            half = `ACPS_HALF_DIV2;
        end else if (code == `ACPS_CODE_DIV4) begin
            half = `ACPS_HALF_DIV4;
        end else if (code == `ACPS_CODE_DIV8) begin
            half = `ACPS_HALF_DIV8;
        end else if (code == `ACPS_CODE_DIV16) begin
            half = `ACPS_HALF_DIV16;
        end else if (code == `ACPS_CODE_DIV32) begin
            half = `ACPS_HALF_DIV32;
        end else if (code == `ACPS_CODE_DIV64) begin
            half = `ACPS_HALF_DIV64;
        end
        return half;
    endfunction

    // rc clock chosen whenever both low select bits are set
    function automatic logic rc_chosen(input logic [2:0] code);
        return code[1:0] == `ACPS_RC_MASK;
    endfunction

    // =========================================================
    // state

    acps_pkg::acps_state_type state;
    acps_pkg::acps_state_type next_state;

    logic [2:0] clk_code;
    logic [3:0] pin_sel;
    assign clk_code = state.select[`ACPS_CLK_HI:`ACPS_CLK_LO];
    assign pin_sel = state.select[`ACPS_PIN_HI:`ACPS_PIN_LO];

    // next state: register port, divider, pin gating
    always_comb begin
        next_state = state;
        // synchronisers for pins and rc oscillator
        next_state.pin_sync1 = converter_input_pins;
        next_state.pin_sync2 = state.pin_sync1;
        next_state.pin_prev = state.pin_sync2;
        next_state.rc_sync1 = rc_osc_in;
        next_state.rc_sync2 = state.rc_sync1;
        // register write, bit 7 not stored
        if (bus_req.write && bus_req.addr == `ACPS_ADDR_SELECT) begin
            next_state.select = bus_req.wdata[6:0];
        end
        // read data valid only in the cycle after the strobe
        next_state.read_data = `ACPS_READ_IDLE;
        if (bus_req.read && bus_req.addr == `ACPS_ADDR_SELECT) begin
            next_state.read_data = {1'b0, state.select};
        end
        // conversion clock source and divider
        next_state.conv_clock_is_rc = rc_chosen(clk_code);
        if (rc_chosen(clk_code)) begin
            next_state.conv_clock = state.rc_sync2;
            next_state.div_count = `ACPS_HALF_ZERO;
        end else if (state.div_count >= half_period(clk_code)) begin
            next_state.conv_clock = ~state.conv_clock;
            next_state.div_count = `ACPS_HALF_ZERO;
        end else begin
            next_state.div_count = state.div_count + `ACPS_HALF_STEP;
        end
        // restart the divider when the code changes
        if (next_state.select[`ACPS_CLK_HI:`ACPS_CLK_LO] != clk_code) begin
            next_state.div_count = `ACPS_HALF_ZERO;
        end
        // per-pin analog or digital routing
        next_state.pins.analog_path_enable = pin_sel;
        next_state.pins.digital_input = state.pin_sync2 & ~pin_sel;
        next_state.pins.pullup_enable = pullup_request & ~pin_sel;
        next_state.pins.change_flag = (state.pin_sync2 ^ state.pin_prev)
            & change_int_enable & ~pin_sel;
        // analog pin still driven as output
        next_state.pins.direction_conflict = pin_sel & ~pin_direction_bits;
    end

    // state register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
            state.select <= `ACPS_SELECT_RESET;
            state.pins.analog_path_enable <= 4'hF;
        end else begin
            state <= next_state;
        end
    end

    // strobes aimed at the select register
    logic select_write;
    logic select_read;
    assign select_write = bus_req.write && bus_req.addr == `ACPS_ADDR_SELECT;
    assign select_read = bus_req.read && bus_req.addr == `ACPS_ADDR_SELECT;

    // outputs straight from flip-flops
    assign read_data = state.read_data;
    assign conv_clock = state.conv_clock;
    assign conv_clock_is_rc = state.conv_clock_is_rc;
    assign pin_out = state.pins;

    // =========================================================
    // assertions

    sequence s_select_write;
        bus_req.write && bus_req.addr == `ACPS_ADDR_SELECT;
    endsequence

    sequence s_select_read;
        bus_req.read && bus_req.addr == `ACPS_ADDR_SELECT;
    endsequence

    a_write_stores: assert property (
        @(posedge clock) disable iff (!reset_n)
        s_select_write |=> state.select == $past(bus_req.wdata[6:0]))
        else $error("select write not stored");

    a_read_answer: assert property (
        @(posedge clock) disable iff (!reset_n)
        s_select_read |=> read_data == {1'b0, $past(state.select)})
        else $error("select read data wrong");

    a_div2_toggle: assert property (
        @(posedge clock) disable iff (!reset_n)
        (clk_code == `ACPS_CODE_DIV2 && !select_write)[*2]
        |=> conv_clock != $past(conv_clock))
        else $error("divide by two clock not toggling");

    a_div_bound: assert property (
        @(posedge clock) disable iff (!reset_n)
        !rc_chosen(clk_code) |-> state.div_count <= half_period(clk_code))
        else $error("divider count beyond half period");

    a_div4_hold: assert property (
        @(posedge clock) disable iff (!reset_n)
        (clk_code == `ACPS_CODE_DIV4 && !select_write)[*3]
        ##0 $changed(conv_clock) |=> $stable(conv_clock))
        else $error("divide by four clock changed too soon");

    a_rc_follow: assert property (
        @(posedge clock) disable iff (!reset_n)
        rc_chosen(clk_code) |=> conv_clock == $past(state.rc_sync2)
            && conv_clock_is_rc)
        else $error("rc clock not passed through");

    a_analog_gate: assert property (
        @(posedge clock) disable iff (!reset_n)
        1'b1 |=> (pin_out.digital_input & $past(pin_sel)) == 4'h0
            && (pin_out.pullup_enable & $past(pin_sel)) == 4'h0
            && (pin_out.change_flag & $past(pin_sel)) == 4'h0
            && pin_out.analog_path_enable == $past(pin_sel))
        else $error("analog pin keeps digital features");

    a_digital_pass: assert property (
        @(posedge clock) disable iff (!reset_n)
        1'b1 |=> (pin_out.digital_input & ~$past(pin_sel))
            == ($past(state.pin_sync2) & ~$past(pin_sel)))
        else $error("digital pin input not passed");

    // read data falls back to idle without a select read
    a_read_idle: assert property (
        @(posedge clock) disable iff (!reset_n)
        !select_read |=> read_data == `ACPS_READ_IDLE)
        else $error("read data not idle");

    // reads of other addresses answer idle
    a_read_other: assert property (
        @(posedge clock) disable iff (!reset_n)
        bus_req.read && bus_req.addr != `ACPS_ADDR_SELECT
        |=> read_data == `ACPS_READ_IDLE)
        else $error("unmapped read not idle");

    // register only moves on a select write
    a_write_other: assert property (
        @(posedge clock) disable iff (!reset_n)
        !select_write |=> $stable(state.select))
        else $error("select changed without write");

    // unused top bit always reads zero
    a_bit7_zero: assert property (
        @(posedge clock) disable iff (!reset_n)
        !read_data[7])
        else $error("top read bit not zero");

    // rc flag follows the select code
    a_rc_flag: assert property (
        @(posedge clock) disable iff (!reset_n)
        1'b1 |=> conv_clock_is_rc == rc_chosen($past(clk_code)))
        else $error("rc flag wrong");

    // divide by eight holds after each edge
    a_div8_hold: assert property (
        @(posedge clock) disable iff (!reset_n)
        (clk_code == `ACPS_CODE_DIV8 && !select_write)[*2]
        ##0 $changed(conv_clock) |=> $stable(conv_clock))
        else $error("divide by eight clock changed too soon");

    // divide by sixteen holds after each edge
    a_div16_hold: assert property (
        @(posedge clock) disable iff (!reset_n)
        (clk_code == `ACPS_CODE_DIV16 && !select_write)[*2]
        ##0 $changed(conv_clock) |=> $stable(conv_clock))
        else $error("divide by sixteen clock changed too soon");

    // divide by thirty-two holds after each edge
    a_div32_hold: assert property (
        @(posedge clock) disable iff (!reset_n)
        (clk_code == `ACPS_CODE_DIV32 && !select_write)[*2]
        ##0 $changed(conv_clock) |=> $stable(conv_clock))
        else $error("divide by thirty-two clock changed too soon");

    // divide by sixty-four holds after each edge
    a_div64_hold: assert property (
        @(posedge clock) disable iff (!reset_n)
        (clk_code == `ACPS_CODE_DIV64 && !select_write)[*2]
        ##0 $changed(conv_clock) |=> $stable(conv_clock))
        else $error("divide by sixty-four clock changed too soon");

    // a new clock code restarts the divider
    a_div_restart: assert property (
        @(posedge clock) disable iff (!reset_n)
        select_write
        && bus_req.wdata[`ACPS_CLK_HI:`ACPS_CLK_LO] != clk_code
        |=> state.div_count == `ACPS_HALF_ZERO)
        else $error("divider not restarted");

    // divider counts up by one below the half period
    a_count_step: assert property (
        @(posedge clock) disable iff (!reset_n)
        !rc_chosen(clk_code) && !select_write
        && state.div_count < half_period(clk_code)
        |=> state.div_count == $past(state.div_count) + `ACPS_HALF_STEP)
        else $error("divider count did not step");

    // reaching the half period toggles the clock
    a_count_wrap: assert property (
        @(posedge clock) disable iff (!reset_n)
        !rc_chosen(clk_code) && state.div_count >= half_period(clk_code)
        |=> conv_clock != $past(conv_clock))
        else $error("divided clock missed its edge");

    // below the half period the clock stands
    a_div_hold: assert property (
        @(posedge clock) disable iff (!reset_n)
        !rc_chosen(clk_code) && state.div_count < half_period(clk_code)
        |=> $stable(conv_clock))
        else $error("divided clock moved early");

    // divider parked while the rc clock runs
    a_rc_count: assert property (
        @(posedge clock) disable iff (!reset_n)
        rc_chosen(clk_code) |=> state.div_count == `ACPS_HALF_ZERO)
        else $error("divider running on rc clock");

    // pull-up requests pass only for digital pins
    a_pullup_pass: assert property (
        @(posedge clock) disable iff (!reset_n)
        1'b1 |=> pin_out.pullup_enable
            == ($past(pullup_request) & ~$past(pin_sel)))
        else $error("pull-up enable wrong");

    // analog pins still driven as outputs are reported
    a_conflict_flag: assert property (
        @(posedge clock) disable iff (!reset_n)
        1'b1 |=> pin_out.direction_conflict
            == ($past(pin_sel) & ~$past(pin_direction_bits)))
        else $error("direction conflict wrong");

    // change pulses only on digital pin edges when enabled
    a_change_flag: assert property (
        @(posedge clock) disable iff (!reset_n)
        1'b1 |=> pin_out.change_flag
            == (($past(state.pin_sync2) ^ $past(state.pin_prev))
            & $past(change_int_enable) & ~$past(pin_sel)))
        else $error("change flag wrong");

    // second pin stage copies the first
    a_pin_sync: assert property (
        @(posedge clock) disable iff (!reset_n)
        1'b1 |=> state.pin_sync2 == $past(state.pin_sync1))
        else $error("pin synchroniser broken");

    // previous pin level copies the synchronised one
    a_pin_prev: assert property (
        @(posedge clock) disable iff (!reset_n)
        1'b1 |=> state.pin_prev == $past(state.pin_sync2))
        else $error("previous pin level broken");

    // second rc stage copies the first
    a_rc_sync: assert property (
        @(posedge clock) disable iff (!reset_n)
        1'b1 |=> state.rc_sync2 == $past(state.rc_sync1))
        else $error("rc synchroniser broken");

endmodule

// >>> verification/acps_bench.sv
// self-checking bench for the clock select and analog pin select block
`timescale 1ns/10ps
module acps_bench;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    acps_pkg::acps_bus_req_type bus_req = '0;
    logic rc_osc_in = 1'b0;
    logic [3:0] pins = 4'h0, dir = 4'h0, pull = 4'h0, chg_en = 4'h0;
    logic [7:0] read_data, rd_val, sel;
    logic conv_clock, conv_clock_is_rc;
    acps_pkg::acps_pin_out_type pin_out;
    logic [3:0] flags, old;
    logic [31:0] seed = 32'hB52AED82;
    int err_count = 0, samples_checked = 0, n, i, k;
    // ========================================
    // clock and design
    always #12.5 clock = ~clock;
    acps_top acps_top_inst (.clock(clock), .reset_n(reset_n),
        .bus_req(bus_req), .read_data(read_data), .rc_osc_in(rc_osc_in),
        .converter_input_pins(pins), .pin_direction_bits(dir),
        .pullup_request(pull), .change_int_enable(chg_en),
        .conv_clock(conv_clock), .conv_clock_is_rc(conv_clock_is_rc),
        .pin_out(pin_out));
    // ========================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // cycles between conversion clock edges for a divided code
    function automatic int half_of(input logic [2:0] c);
        case (c)
            3'h0: return 1;
            3'h4: return 2;
            3'h1: return 4;
            3'h5: return 8;
            3'h2: return 16;
            default: return 32;
        endcase
    endfunction
    task automatic stop_test();
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge clock);
        bus_req.write <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
        @(posedge clock);
        bus_req.read <= 1'b0;
        @(negedge clock);
        d = read_data;
    endtask
    // bounded wait for the next conversion clock edge, cycles in n
    task automatic wait_edge();
        logic l;
        l = conv_clock;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (conv_clock === l && n < 200);
        if (n >= 200) begin
            err_count++;
            stop_test();
        end
    endtask
    // ========================================
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        rd(8'h9F, rd_val);
        check("reset value", rd_val, 8'h0F);
        rd(8'h9E, rd_val);
        check("unmapped read", rd_val, 8'h00);
        wr(8'h9E, 8'hFF);
        rd(8'h9F, rd_val);
        check("unmapped write", rd_val, 8'h0F);
        // random register values, bit 7 reads zero
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wr(8'h9F, seed[7:0]);
            rd(8'h9F, rd_val);
            check("readback", rd_val, seed[7:0] & 8'h7F);
        end
        // every clock code, divided and internal rc
        for (i = 0; i < 8; i++) begin
            wr(8'h9F, {1'b0, i[2:0], 4'h0});
            repeat (4) @(posedge clock);
            check("rc flag", {7'h0, conv_clock_is_rc},
                  {7'h0, i[1:0] == 2'h3});
            if (i[1:0] == 2'h3) begin
                for (k = 0; k < 2; k++) begin
                    rc_osc_in <= ~k[0];
                    repeat (6) @(posedge clock);
                    @(negedge clock);
                    check("rc clock", {7'h0, conv_clock}, {7'h0, ~k[0]});
                end
            end else begin
                wait_edge();
                wait_edge();
                check("half period", n[7:0], half_of(i[2:0]));
            end
        end
        // pin gating with random pins, selects and requests
        for (i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            sel = {1'b0, seed[6:4], (i == 0) ? 4'h0 : seed[3:0]};
            wr(8'h9F, sel);
            @(posedge clock);
            pins <= seed[11:8];
            dir <= seed[15:12];
            pull <= seed[19:16];
            chg_en <= seed[23:20];
            repeat (6) @(posedge clock);
            @(negedge clock);
            check("analog path", pin_out.analog_path_enable, sel[3:0]);
            check("digital in", pin_out.digital_input,
                  pins & ~sel[3:0]);
            check("pullup", pin_out.pullup_enable, pull & ~sel[3:0]);
            check("conflict", pin_out.direction_conflict,
                  sel[3:0] & ~dir);
            old = pins;
            @(posedge clock);
            pins <= seed[27:24];
            flags = 4'h0;
            repeat (6) begin
                @(negedge clock);
                flags = flags | pin_out.change_flag;
            end
            check("change flag", flags,
                  (old ^ seed[27:24]) & chg_en & ~sel[3:0]);
        end
        stop_test();
    end
endmodule
